// *** rtl/irx_ctl.sv ***
// Host-side controller for an infrared transceiver front end.

// Notes on behaviour
// - Mode pin low selects low bandwidth, high selects high bandwidth.
// - High mode: shutdown up, transmit up, 200 ns, shutdown down, 200 ns.
// - Low mode: shutdown up, transmit low, 200 ns, drop, hold 200 ns.
// - After the shutdown fall, transmit high stays within the pulse limit.
module irx_ctl (
   // Clock, reset and clock enable
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // User control
   input wire logic mode_req,
   input wire logic mode_high,
   input wire logic use_pin,
   input wire logic sleep,
   input wire logic tx_data,
   // User status
   output logic busy,
   output logic mode_hi,
   output logic rx_data,
   output logic tx_cut,
   // Transceiver pins
   output logic sd_o,
   output logic txd_o,
   output logic mode_o,
   output logic mode_oe,
   input wire logic rxd_i
);

   irx_pkg::irx_ctl_t q;
   irx_pkg::irx_ctl_t d;

   irx_sync_if sif ();

   assign sif.raw = rxd_i;

   irx_sync u_sync (
      .mclk (mclk),
      .rstn (rstn),
      .ce (ce),
      .sif (sif)
   );

   always_comb begin
      d = q;
      if (ce) begin
         d.cut_p = 1'b0;
         case (q.st)
            irx_pkg::ST_RUN: begin
               d.sd = 1'b0;
               if (mode_req && use_pin) begin
                  d.pin_mode = 1'b1;
                  d.mode_hi = mode_high;
               end else if (mode_req) begin
                  d.pin_mode = 1'b0;
                  d.target = mode_high;
                  d.st = irx_pkg::ST_SETUP;
                  d.sd = 1'b1;
                  d.txd = mode_high;
                  d.cnt = '0;
               end else if (sleep) begin
                  d.st = irx_pkg::ST_SHUT;
                  d.sd = 1'b1;
                  d.txd = 1'b0;
               end else begin
                  d.txd = tx_data & ~q.cut;
               end
            end
            irx_pkg::ST_SETUP: begin
               if (q.cnt == irx_pkg::SETUP_LAST) begin
                  d.st = irx_pkg::ST_HOLD;
                  d.sd = 1'b0;
                  d.cnt = '0;
               end else begin
                  d.cnt = q.cnt + 1'b1;
               end
            end
            irx_pkg::ST_HOLD: begin
               // hold exactly the least time, then release
               if (q.cnt == irx_pkg::HOLD_LAST) begin
                  d.st = irx_pkg::ST_RUN;
                  // device has latched the target level
                  d.mode_hi = q.target;
                  d.txd = 1'b0;
                  d.cnt = '0;
               end else begin
                  d.cnt = q.cnt + 1'b1;
               end
            end
            irx_pkg::ST_SHUT: begin
               if (mode_req && !use_pin) begin
                  d.pin_mode = 1'b0;
                  d.target = mode_high;
                  d.st = irx_pkg::ST_SETUP;
                  d.txd = mode_high;
                  d.cnt = '0;
               end else if (mode_req) begin
                  d.pin_mode = 1'b1;
                  d.mode_hi = mode_high;
               end else if (!sleep) begin
                  // A plain release would latch a low transmit level.
                  // replay held mode
                  d.target = q.mode_hi;
                  d.st = irx_pkg::ST_SETUP;
                  d.txd = q.mode_hi;
                  d.cnt = '0;
               end
            end
            default: begin
               d.st = irx_pkg::ST_RUN;
               d.sd = 1'b0;
               d.txd = 1'b0;
            end
         endcase
         // pulse guard, cut stays until data drops
         if (q.txd && q.st == irx_pkg::ST_RUN
             && d.st == irx_pkg::ST_RUN) begin
            if (q.txc == irx_pkg::TXD_LAST) begin
               d.cut = 1'b1;
               d.cut_p = 1'b1;
               d.txd = 1'b0;
               d.txc = '0;
            end else begin
               d.txc = q.txc + 1'b1;
            end
         end else begin
            d.txc = '0;
         end
         if (!tx_data) begin
            d.cut = 1'b0;
         end
         // receive is active low; ignore it while shut down
         d.rx = d.sd ? irx_pkg::RX_IDLE : sif.lvl;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q <= '{st: irx_pkg::ST_RUN, mode_hi: irx_pkg::MODE_RST,
                rx: irx_pkg::RX_IDLE, default: '0};
      end else begin
         q <= d;
      end
   end

   assign busy = (q.st != irx_pkg::ST_RUN);
   assign mode_hi = q.mode_hi;
   assign rx_data = q.rx;
   assign tx_cut = q.cut_p;
   assign sd_o = q.sd;
   assign txd_o = q.txd;
   assign mode_o = q.mode_hi;
   assign mode_oe = q.pin_mode;

   // Helper counters that only the checks below read.
   localparam int SETUP_MIN = irx_pkg::SETUP_CYC - 1;
   localparam int HOLD_MIN = irx_pkg::HOLD_CYC - 1;
   logic [irx_pkg::CNT_W-1:0] sc_q;
   logic [irx_pkg::CNT_W-1:0] hc_q;
   logic [irx_pkg::CNT_W-1:0] th_q;
   logic txd_prev_q;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sc_q <= '0;
         hc_q <= '0;
         th_q <= '0;
         txd_prev_q <= 1'b0;
      end else begin
         txd_prev_q <= txd_o;
         if (!sd_o || txd_o != txd_prev_q) begin
            sc_q <= '0;
         end else if (sc_q != '1) begin
            sc_q <= sc_q + 1'b1;
         end
         if (sd_o || txd_o != txd_prev_q) begin
            hc_q <= '0;
         end else if (hc_q != '1) begin
            hc_q <= hc_q + 1'b1;
         end
         if (!txd_o) begin
            th_q <= '0;
         end else if (th_q != '1) begin
            th_q <= th_q + 1'b1;
         end
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   sequence s_fall;
      $fell(sd_o);
   endsequence

   sequence s_hold_end;
      $past(q.st == irx_pkg::ST_HOLD) && $changed(txd_o);
   endsequence

   property p_setup;
      s_fall |-> sc_q >= SETUP_MIN;
   endproperty
   a_setup: assert property (p_setup)
      else $error("shutdown fell before setup time");

   property p_hold;
      s_hold_end |-> $past(hc_q) >= HOLD_MIN;
   endproperty
   a_hold: assert property (p_hold)
      else $error("transmit released before hold time");

   property p_latch;
      s_fall |-> txd_o == $past(txd_o) ##1 txd_o == $past(txd_o);
   endproperty
   a_latch: assert property (p_latch)
      else $error("transmit moved at the shutdown fall");

   property p_pulse;
      int'(th_q) <= irx_pkg::TXD_MAX_CYC;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("transmit high beyond the pulse limit");

   property p_pin;
      (ce && mode_req && use_pin && q.st == irx_pkg::ST_RUN)
         |=> mode_oe && mode_o == $past(mode_high);
   endproperty
   a_pin: assert property (p_pin)
      else $error("mode pin does not follow the request");

endmodule : irx_ctl

// *** rtl/irx_pkg.sv ***
// Shared constants and types for the infrared transceiver mode controller.
package irx_pkg;

   // Clock period of mclk in ns.
   localparam int CLK_NS = 25;

   // Least setup and hold of the transmit pin around the shutdown fall.
   localparam int SETUP_NS = 200;
   localparam int HOLD_NS = 200;

   // Longest transmit pulse before the guard cuts it, in ns.
   localparam int TXD_MAX_NS = 80000;

   // Least times round up, the longest time rounds down.
   localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int TXD_MAX_CYC = TXD_MAX_NS / CLK_NS;

   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYC - 1);
   localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);
   localparam logic [CNT_W-1:0] TXD_LAST = CNT_W'(TXD_MAX_CYC - 1);

   // Mode assumed after reset: low bandwidth.
   localparam logic MODE_RST = 1'b0;
   // Receive line level while idle.
   localparam logic RX_IDLE = 1'b1;

   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_SETUP = 2'h1,
      ST_HOLD = 2'h3,
      ST_SHUT = 2'h2
   } irx_state_t;

   typedef struct packed {
      irx_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] txc;
      logic cut;
      logic cut_p;
      logic target;
      logic mode_hi;
      logic pin_mode;
      logic sd;
      logic txd;
      logic rx;
   } irx_ctl_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } irx_sync_t;

endpackage : irx_pkg

// *** rtl/irx_sync.sv ***
// Three-stage synchroniser and agreement filter for the receive pin.
module irx_sync (
   // Clock, reset and clock enable
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // Pin in, filtered level out
   irx_sync_if.filt sif
);

   irx_pkg::irx_sync_t q;
   irx_pkg::irx_sync_t d;

   always_comb begin
      d = q;
      if (ce) begin
         d.s1 = sif.raw;
         d.s2 = q.s1;
         d.s3 = q.s2;
         // A change counts once the second and third stages agree.
         if (q.s2 == q.s3) begin
            d.lvl = q.s3;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         q <= {4{irx_pkg::RX_IDLE}};
      end else begin
         q <= d;
      end
   end

   assign sif.lvl = q.lvl;

endmodule : irx_sync

// *** rtl/irx_sync_if.sv ***
// Carrier between the controller and its receive pin filter.
interface irx_sync_if;
   logic raw;
   logic lvl;
   modport filt (input raw, output lvl);
   modport user (output raw, input lvl);
endinterface : irx_sync_if

// *** tb/irx_dev_model.sv ***
// Behavioural model of the infrared transceiver front end.
module irx_dev_model (
   // Pins from the host
   input wire logic sd,
   input wire logic txd,
   input wire logic mode_pin,
   input wire logic mode_oe,
   // Optical side and observation
   input wire logic light,
   output logic rxd,
   output logic led,
   output logic bw_hi,
   output int viol
);
   timeunit 1ns;
   timeprecision 1ps;
   realtime t_up = 0, t_tx = 0, t_fall = -1e6, t_hi = 0;
   logic lat = 1'b0;
   logic flt = 1'b0;
   logic txd_was = 1'b0;
   initial viol = 0;
   // A floating pin must not look stable to the host.
   always #25 flt = ~flt;
   always @(posedge sd) t_up = $realtime;
   always @(negedge sd) begin
      // Only falls after a real rise count; the reset settle is ignored.
      if (t_up > 0) begin
         if ($realtime - t_tx < 200 || $realtime - t_up < 200) viol++;
         lat = txd;
         t_fall = $realtime;
      end
   end
   always @(txd) begin
      if (!sd && $realtime - t_fall < 200) viol++;
      t_tx = $realtime;
   end
   assign bw_hi = mode_oe ? mode_pin : lat;
   // truth table
   // The pulse start is taken here so the emitter never sees a stale one.
   always @(sd, txd, light, flt) begin
      if (txd === 1'b1 && txd_was !== 1'b1) t_hi = $realtime;
      txd_was = txd;
      led = !sd && txd && ($realtime - t_hi < 80000);
      rxd = sd ? flt : (txd | !light);
   end
endmodule : irx_dev_model

// *** tb/testbench.sv ***
// Self-checking bench for the transceiver mode controller.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, mode_req = 1'b0;
   logic mode_high = 1'b0, use_pin = 1'b0, sleep = 1'b0, tx_data = 1'b0;
   logic light = 1'b0, busy, mode_hi, rx_data, tx_cut, sd_o, txd_o;
   logic mode_o, mode_oe, rxd, led, bw_hi, cut_seen;
   logic [31:0] lf = 32'hdb1b3121;
   int viol, n, n_mismatch = 0, cmp_count = 0, cyc = 0;
   int exp_q[$] = '{1, 0, 1};

   always #12.5 mclk = ~mclk;

   irx_ctl uut (.mclk(mclk), .rstn(rstn), .ce(ce), .mode_req(mode_req),
      .mode_high(mode_high), .use_pin(use_pin), .sleep(sleep),
      .tx_data(tx_data), .busy(busy), .mode_hi(mode_hi), .rx_data(rx_data),
      .tx_cut(tx_cut), .sd_o(sd_o), .txd_o(txd_o), .mode_o(mode_o),
      .mode_oe(mode_oe), .rxd_i(rxd));
   irx_dev_model dev (.sd(sd_o), .txd(txd_o), .mode_pin(mode_o),
      .mode_oe(mode_oe), .light(light), .rxd(rxd), .led(led),
      .bw_hi(bw_hi), .viol(viol));

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 12000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : step

   task automatic chk(input string what, input logic seen, input logic exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %b seen %b", what, exp, seen);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : report_and_stop

   task automatic done(input string what);
      $display("Test %s finished", what);
   endtask : done

   task automatic req(input logic hi, input logic pin);
      mode_req = 1'b1;
      mode_high = hi;
      use_pin = pin;
      @(negedge mclk);
      mode_req = 1'b0;
      n = 0;
      while (busy === 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      chk("busy_cycles", n == (pin ? 0 : 16), 1'b1);
      chk("mode_hi", mode_hi, hi);
      chk("device_mode", bw_hi, hi);
      chk("mode_oe", mode_oe, pin);
      chk("setup_hold", viol == 0, 1'b1);
      if (pin) chk("mode_pin", mode_o, hi);
   endtask : req

   initial begin
      repeat (12) @(negedge mclk);
      rstn = 1'b1;
      chk("mode_hi", mode_hi, 1'b0);
      chk("device_mode", bw_hi, 1'b0);
      done("reset");
      foreach (exp_q[i]) req(1'(exp_q[i]), 1'b0);
      req(1'b0, 1'b1);
      req(1'b1, 1'b1);
      req(1'b0, 1'b0);
      done("mode");
      repeat (40) begin
         lf = step(lf);
         tx_data = lf[0];
         @(negedge mclk);
         chk("txd_o", txd_o, tx_data);
         chk("emitter", led, tx_data);
      end
      ce = 1'b0;
      tx_data = ~txd_o;
      repeat (4) @(negedge mclk);
      chk("ce_hold", txd_o, ~tx_data);
      ce = 1'b1;
      tx_data = 1'b0;
      for (int i = 0; i < 4; i++) begin
         light = ~light;
         repeat (8) @(negedge mclk);
         chk("rx_data", rx_data, !light);
         chk("rxd_pin", rxd, !light);
      end
      done("data");
      req(1'b1, 1'b0);
      sleep = 1'b1;
      tx_data = 1'b1;
      repeat (12) @(negedge mclk);
      chk("sd_o", sd_o, 1'b1);
      chk("txd_o", txd_o, 1'b0);
      chk("rx_data", rx_data, 1'b1);
      chk("emitter", led, 1'b0);
      sleep = 1'b0;
      tx_data = 1'b0;
      light = 1'b0;
      repeat (20) @(negedge mclk);
      chk("sd_o", sd_o, 1'b0);
      chk("busy", busy, 1'b0);
      chk("mode_hi", mode_hi, 1'b1);
      chk("device_mode", bw_hi, 1'b1);
      chk("setup_hold", viol == 0, 1'b1);
      done("sleep");
      tx_data = 1'b1;
      n = 0;
      cut_seen = 1'b0;
      @(negedge mclk);
      while (txd_o === 1'b1 && n < 4000) begin
         @(negedge mclk);
         n++;
         cut_seen |= tx_cut;
      end
      @(negedge mclk);
      cut_seen |= tx_cut;
      chk("cut_time", n >= 3190 && n <= 3200, 1'b1);
      chk("tx_cut", cut_seen, 1'b1);
      chk("emitter", led, 1'b0);
      chk("txd_o", txd_o, 1'b0);
      done("guard");
      report_and_stop();
   end
endmodule : testbench
